// *** arc_reclose.sv ***
// Purpose: Dead time, breaker and sync checks, close pulse and reclaim of a reclose sequencer
// Assumes: Inputs are asynchronous levels; settings and control reached over APB
// Notes:   One wait timer shared by all states, advanced by a common 1 ms tick
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
// Overview of operation
// RULE1: First cycle uses special three-phase dead time when its fault input is set.
// RULE2: Reduced dead time input ends a running dead time at once.
// RULE3: Without three-phase trip, single-phase dead times are used.
// RULE4: With three-phase trip, each cycle uses its three-phase dead time.
// RULE5: Once three-phase timing is used, later cycles keep it.
// RULE6: Three-phase trip with three-phase reclose disabled enters dynamic block.
// RULE7: Reclose is issued only while the breaker reports ready.
// RULE8: Wait for breaker ready up to supervision time, else dynamic block.
// RULE9: Reclose needs sync release, waited for up to the sync check time.
// RULE10: Sync release missing the whole wait starts sync switching with close request.
// RULE11: Sync switching runs its own bounded timer; close request stays high.
// RULE12: Sync switching timeout enters dynamic block and ends the sequence.
// RULE13: Close output is one common pulse of the close pulse time.
// RULE14: Reclaim starts with close and lasts at least until the pulse ends.
// RULE15: Trip during reclaim continues with the next cycle.
// RULE16: Reclaim expiry without fault marks success and returns idle.
// RULE17: Fault after reclaim expiry starts again at cycle one.
// RULE18: Protection start seen in reclaim keeps the sequence for a later trip.
// RULE19: Manual close holds not-ready for the block-after-manual-close time.
// RULE20: Manual close during a running cycle enters dynamic block.
// RULE21: Separate single and three-phase dead times exist for four cycles.
// RULE22: Dynamic block runs its timer and allows no close meanwhile.
// RULE23: Blocked output is high in dynamic block and in not-ready.
// RULE24: Timers count common ticks and compare against their setting.
// RULE25: Breaker, sync check and sync switch waits are successive states.
module arc_reclose #(
  parameter int TICK_CYCLES = arc_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        general_trip_in,
  input  wire logic        three_phase_trip_in,
  input  wire logic        first_cycle_3ph_fault_in,
  input  wire logic        reduced_dead_time_in,
  input  wire logic        breaker_ready_in,
  input  wire logic        sync_release_in,
  input  wire logic        protection_start_in,
  input  wire logic        manual_close_in,
  output logic             close_pulse_out,
  output logic             close_request_out,
  output logic             blocked_status_out
);
  import arc_pkg::*;

  logic [NIN-1:0]  raw;
  logic [NIN-1:0]  s1_ff;
  logic [NIN-1:0]  s2_ff;
  logic [NIN-1:0]  s3_ff;
  logic [NIN-1:0]  in_ff;
  logic            mcq_ff;
  logic [TW-1:0]   set_ff [NSET];
  logic [3:0]      ctl_ff;
  logic            succ_ff;
  logic            pready_ff;
  logic            pslverr_ff;
  logic [31:0]     prdata_ff;
  logic [31:0]     rd_data;
  logic [14:0]     div_ff;
  logic            tick_ff;
  arc_state_t      st_ff;
  arc_state_t      nxt_st;
  logic [1:0]      cyc_ff;
  logic [1:0]      nxt_cyc;
  logic            used_ff;
  logic            nxt_used;
  logic            stseen_ff;
  logic            nxt_stseen;
  logic [TW-1:0]   tmr_ff;
  logic [TW-1:0]   ccnt_ff;
  logic            close_ff;
  logic [TW-1:0]   mcnt_ff;
  logic            mrun_ff;
  logic            req_ff;
  logic            blk_ff;
  logic            issue;
  logic            succ_ev;
  logic            trip;
  logic            tph;
  logic            fc3;
  logic            rdt;
  logic            rdy;
  logic            sync;
  logic            pstart;
  logic            mc_ev;
  logic            en;
  logic            dis3;
  logic [1:0]      ncyc;
  logic [TW-1:0]   dt_sel;
  logic            acc;
  logic            wr;
  logic            mapped;

  assign raw = {manual_close_in, protection_start_in, sync_release_in, breaker_ready_in,
                reduced_dead_time_in, first_cycle_3ph_fault_in, three_phase_trip_in,
                general_trip_in};

  // Input filter: a change is taken once two late stages agree
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          s1_ff[gi] <= 1'b0;
          s2_ff[gi] <= 1'b0;
          s3_ff[gi] <= 1'b0;
          in_ff[gi] <= 1'b0;
        end else begin
          s1_ff[gi] <= raw[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          if (s2_ff[gi] == s3_ff[gi]) begin
            in_ff[gi] <= s3_ff[gi];
          end
        end
      end
    end
  endgenerate

  assign trip   = in_ff[0];
  assign tph    = in_ff[1];
  assign fc3    = in_ff[2];
  assign rdt    = in_ff[3];
  assign rdy    = in_ff[4];
  assign sync   = in_ff[5];
  assign pstart = in_ff[6];
  assign mc_ev  = in_ff[7] & ~mcq_ff;
  assign en     = ctl_ff[CTL_EN];
  assign dis3   = ctl_ff[CTL_DIS3];
  assign ncyc   = ctl_ff[CTL_NCYC +: 2];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mcq_ff <= 1'b0;
    end else begin
      mcq_ff <= in_ff[7];
    end
  end

  // Common timer tick
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (div_ff == 15'(TICK_CYCLES - 1)) begin
      div_ff  <= '0;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + 15'h1;
      tick_ff <= 1'b0;
    end
  end

  // Dead time choice per cycle and trip kind
  always_comb begin
    if (!used_ff) begin
      dt_sel = set_ff[IDX_DEAD_1PH + {2'b00, cyc_ff}]; // RULE3 RULE21
    end else if (cyc_ff == 2'h0 && fc3) begin
      dt_sel = set_ff[FIRST_CYCLE_SPECIAL_3PH_DEAD_TIME]; // RULE1
    end else begin
      dt_sel = set_ff[IDX_DEAD_3PH + {2'b00, cyc_ff}]; // RULE4 RULE5 RULE21
    end
  end

  always_comb begin
    nxt_st     = st_ff;
    nxt_cyc    = cyc_ff;
    nxt_used   = used_ff;
    nxt_stseen = stseen_ff;
    issue      = 1'b0;
    succ_ev    = 1'b0;
    case (st_ff)
      S_IDLE: begin
        if (trip && en && !mrun_ff) begin
          nxt_cyc  = 2'h0; // RULE17
          nxt_used = tph;
          nxt_st   = (tph && dis3) ? S_DYN : S_TRIP; // RULE6
        end
      end
      S_TRIP: begin
        if (tph) begin
          nxt_used = 1'b1; // RULE4
        end
        if (tph && dis3) begin
          nxt_st = S_DYN; // RULE6
        end else if (!trip) begin
          nxt_st = S_DEAD;
        end
      end
      S_DEAD: begin
        if (rdt || tmr_ff >= dt_sel) begin
          nxt_st = S_CBW; // RULE2
        end
      end
      S_CBW: begin
        if (rdy) begin
          nxt_st = S_SYN; // RULE25
        end else if (tmr_ff >= set_ff[BREAKER_SUPERVISION_TIME]) begin
          nxt_st = S_DYN; // RULE8
        end
      end
      S_SYN: begin
        if (sync && rdy) begin
          issue = 1'b1; // RULE7 RULE9
        end else if (tmr_ff >= set_ff[SYNC_CHECK_MAX_TIME]) begin
          nxt_st = S_SYNSW; // RULE10
        end
      end
      S_SYNSW: begin
        if (sync && rdy) begin
          issue = 1'b1; // RULE7
        end else if (tmr_ff >= set_ff[SYNC_SWITCH_MAX_TIME]) begin
          nxt_st = S_DYN; // RULE12
        end
      end
      S_RECL, S_POST: begin
        if (st_ff == S_RECL && pstart) begin
          nxt_stseen = 1'b1; // RULE18
        end
        if (trip) begin
          if (cyc_ff >= ncyc) begin
            nxt_st = S_DYN; // Last cycle used up
          end else begin
            nxt_cyc  = cyc_ff + 2'h1; // RULE15
            nxt_used = used_ff | tph; // RULE5
            nxt_st   = (tph && dis3) ? S_DYN : S_TRIP; // RULE6
          end
        end else if (st_ff == S_POST) begin
          if (!pstart) begin
            succ_ev = 1'b1;
          end
        end else if (tmr_ff >= set_ff[RECLAIM_TIME] && !close_ff) begin
          if (stseen_ff || pstart) begin
            nxt_st = S_POST; // RULE18
          end else begin
            succ_ev = 1'b1; // RULE14 RULE16
          end
        end
      end
      S_DYN: begin
        if (tmr_ff >= set_ff[DYNAMIC_BLOCKING_TIME]) begin
          nxt_st = S_IDLE; // RULE22
        end
      end
      default: nxt_st = S_IDLE;
    endcase
    if (issue) begin
      nxt_st     = S_RECL;
      nxt_stseen = 1'b0;
    end
    if (succ_ev) begin
      nxt_st = S_IDLE; // RULE16
    end
    // Manual close wins over a close or a success decided in the same cycle
    if (mc_ev && st_ff != S_IDLE && st_ff != S_DYN) begin
      nxt_st  = S_DYN; // RULE20
      issue   = 1'b0; // RULE22
      succ_ev = 1'b0;
    end
    if (nxt_st == S_IDLE) begin
      nxt_cyc  = 2'h0;
      nxt_used = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff     <= S_IDLE;
      cyc_ff    <= 2'h0;
      used_ff   <= 1'b0;
      stseen_ff <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      cyc_ff    <= nxt_cyc;
      used_ff   <= nxt_used;
      stseen_ff <= nxt_stseen;
    end
  end

  // One wait timer, cleared on every state change so waits never overlap
  always_ff @(posedge clk) begin
    if (!rst_n || nxt_st != st_ff || issue) begin
      tmr_ff <= '0; // RULE25
    end else if (tick_ff && tmr_ff != '1) begin
      tmr_ff <= tmr_ff + 16'h1; // RULE24
    end
  end

  // Close pulse; a new trip also cuts it since the state is left
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      close_ff <= 1'b0;
      ccnt_ff  <= '0;
    end else if (issue) begin
      close_ff <= 1'b1; // RULE13
      ccnt_ff  <= '0;
    end else if (nxt_st != S_RECL || ccnt_ff >= set_ff[CLOSE_PULSE_TIME]) begin
      close_ff <= 1'b0; // RULE13
    end else if (tick_ff) begin
      ccnt_ff <= ccnt_ff + 16'h1; // RULE24
    end
  end

  // Not-ready after manual close
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mrun_ff <= 1'b0;
      mcnt_ff <= '0;
    end else if (mc_ev) begin
      mrun_ff <= 1'b1; // RULE19
      mcnt_ff <= '0;
    end else if (mcnt_ff >= set_ff[BLOCK_AFTER_MANUAL_CLOSE_TIME]) begin
      mrun_ff <= 1'b0; // RULE19
    end else if (tick_ff && mrun_ff) begin
      mcnt_ff <= mcnt_ff + 16'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_ff <= 1'b0;
      blk_ff <= 1'b0;
    end else begin
      req_ff <= (nxt_st == S_SYNSW); // RULE10 RULE11
      blk_ff <= (nxt_st == S_DYN) ||
                (nxt_st == S_IDLE && (mrun_ff || mc_ev || !en || !rdy)); // RULE23
    end
  end

  assign close_pulse_out    = close_ff;
  assign close_request_out  = req_ff;
  assign blocked_status_out = blk_ff;

  // APB slave: one wait state, write lands on the completing edge
  assign acc    = psel & penable;
  // Misaligned or unmapped writes must not alias onto a setting slot
  assign wr     = acc & pready_ff & pwrite & mapped;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_STAT);

  generate
    for (gi = 0; gi < NSET; gi++) begin : g_set
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          set_ff[gi] <= RST_TIME;
        end else if (wr && paddr[7:6] == 2'b00 && paddr[5:2] == 4'(gi)) begin
          set_ff[gi] <= pwdata[TW-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_ff <= RST_CTRL;
    end else if (wr && paddr == OFS_CTRL) begin
      ctl_ff <= pwdata[3:0];
    end
  end

  // Success flag: a new success wins over a clearing write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      succ_ff <= 1'b0;
    end else if (succ_ev) begin
      succ_ff <= 1'b1;
    end else if (wr && paddr == OFS_STAT && pwdata[ST_SUCC]) begin
      succ_ff <= 1'b0;
    end
  end

  always_comb begin
    rd_data = '0;
    if (paddr[7:6] == 2'b00) begin
      rd_data[TW-1:0] = set_ff[paddr[5:2]];
    end else if (paddr == OFS_CTRL) begin
      rd_data[3:0] = ctl_ff;
    end else if (paddr == OFS_STAT) begin
      rd_data[ST_STATE +: 4] = st_ff;
      rd_data[ST_CYC +: 2]   = cyc_ff;
      rd_data[ST_3PH]        = used_ff;
      rd_data[ST_BLK]        = blk_ff;
      rd_data[ST_REQ]        = req_ff;
      rd_data[ST_CLOSE]      = close_ff;
      rd_data[ST_NRDY]       = mrun_ff;
      rd_data[ST_SUCC]       = succ_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else begin
      pready_ff  <= acc & ~pready_ff;
      pslverr_ff <= acc & ~pready_ff & ~mapped;
      if (acc && !pready_ff) begin
        prdata_ff <= mapped ? rd_data : 32'h0000_0000;
      end
    end
  end

  assign pready  = pready_ff;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence syn_expire;
    st_ff == S_SYN && !(sync && rdy) && !mc_ev && tmr_ff >= set_ff[SYNC_CHECK_MAX_TIME];
  endsequence
  sequence synsw_expire;
    st_ff == S_SYNSW && !(sync && rdy) && !mc_ev
      && tmr_ff >= set_ff[SYNC_SWITCH_MAX_TIME];
  endsequence

  a_special_dt: assert property ( // RULE1
    (st_ff == S_DEAD && used_ff && cyc_ff == 2'h0 && fc3)
      |-> dt_sel == set_ff[FIRST_CYCLE_SPECIAL_3PH_DEAD_TIME])
    else $error("special dead time not chosen");
  a_reduced_end: assert property ( // RULE2
    (st_ff == S_DEAD && rdt && !mc_ev) |=> st_ff == S_CBW)
    else $error("reduced dead time ignored");
  a_single_dt: assert property ( // RULE3
    (st_ff == S_DEAD && !used_ff) |-> dt_sel == set_ff[{2'b00, cyc_ff}])
    else $error("single phase dead time wrong");
  a_three_sticky: assert property ( // RULE5
    (used_ff && nxt_st != S_IDLE) |=> used_ff)
    else $error("three phase timing dropped");
  a_dis3_block: assert property ( // RULE6
    (st_ff == S_TRIP && tph && dis3) |=> st_ff == S_DYN)
    else $error("disabled three phase reclose not blocked");
  a_ready_close: assert property ( // RULE7
    $rose(close_pulse_out) |-> $past(rdy))
    else $error("close without breaker ready");
  a_cb_timeout: assert property ( // RULE8
    (st_ff == S_CBW && !rdy && !mc_ev && tmr_ff >= set_ff[BREAKER_SUPERVISION_TIME])
      |=> st_ff == S_DYN)
    else $error("breaker wait did not block");
  a_sync_request: assert property ( // RULE10
    syn_expire |=> st_ff == S_SYNSW ##0 close_request_out
      ##1 (close_request_out || st_ff != S_SYNSW))
    else $error("sync switching not started");
  a_synsw_fail: assert property ( // RULE12
    synsw_expire |=> st_ff == S_DYN && !close_request_out)
    else $error("sync switch timeout not blocked");
  a_close_len: assert property ( // RULE13
    ($fell(close_pulse_out) && $past(st_ff) == S_RECL && !$past(trip) && !$past(mc_ev))
      |-> $past(ccnt_ff) >= $past(set_ff[CLOSE_PULSE_TIME]))
    else $error("close pulse too short");
  a_reclaim_ext: assert property ( // RULE14
    (st_ff == S_RECL && close_pulse_out && !trip && !mc_ev) |=> st_ff == S_RECL)
    else $error("reclaim ended during close pulse");
  a_start_hold: assert property ( // RULE18
    (st_ff == S_RECL && pstart && !trip && !mc_ev && !close_ff
      && tmr_ff >= set_ff[RECLAIM_TIME]) |=> st_ff == S_POST)
    else $error("protection start not held after reclaim");
  a_manual_dyn: assert property ( // RULE20
    (mc_ev && st_ff != S_IDLE && st_ff != S_DYN) |=> st_ff == S_DYN)
    else $error("manual close in cycle not blocked");
  a_dyn_quiet: assert property ( // RULE22
    st_ff == S_DYN |-> !close_pulse_out && !close_request_out)
    else $error("close activity in dynamic block");
  a_blocked_out: assert property ( // RULE23
    (st_ff == S_DYN || (st_ff == S_IDLE && mrun_ff)) |-> blocked_status_out)
    else $error("blocked status missing");
endmodule

// *** arc_pkg.sv ***
// Purpose: Shared constants and types of the reclose sequencer
// Assumes: 20 MHz clock; all setting values are counted in 1 ms ticks
// Notes:   Register map is word aligned on APB
package arc_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_TIME_NS  = 1000000;
  localparam int TICK_CYCLES   = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TW            = 16;
  localparam int NSET          = 16;
  localparam int NIN           = 8;

  // Setting slots, byte address is four times the slot
  localparam logic [3:0] IDX_DEAD_1PH                      = 4'h0;
  localparam logic [3:0] IDX_DEAD_3PH                      = 4'h4;
  localparam logic [3:0] FIRST_CYCLE_SPECIAL_3PH_DEAD_TIME = 4'h8;
  localparam logic [3:0] CLOSE_PULSE_TIME                  = 4'h9;
  localparam logic [3:0] RECLAIM_TIME                      = 4'ha;
  localparam logic [3:0] BREAKER_SUPERVISION_TIME          = 4'hb;
  localparam logic [3:0] SYNC_CHECK_MAX_TIME               = 4'hc;
  localparam logic [3:0] SYNC_SWITCH_MAX_TIME              = 4'hd;
  localparam logic [3:0] BLOCK_AFTER_MANUAL_CLOSE_TIME     = 4'he;
  localparam logic [3:0] DYNAMIC_BLOCKING_TIME             = 4'hf;

  localparam logic [7:0] OFS_CTRL = 8'h40;
  localparam logic [7:0] OFS_STAT = 8'h44;

  localparam int CTL_EN   = 0;
  localparam int CTL_DIS3 = 1;
  localparam int CTL_NCYC = 2;
  localparam int ST_STATE = 0;
  localparam int ST_CYC   = 4;
  localparam int ST_3PH   = 6;
  localparam int ST_BLK   = 7;
  localparam int ST_REQ   = 8;
  localparam int ST_CLOSE = 9;
  localparam int ST_NRDY  = 10;
  localparam int ST_SUCC  = 16;

  localparam logic [TW-1:0] RST_TIME  = 16'h03e8;
  localparam logic [3:0]    RST_CTRL  = 4'h1;

  typedef enum logic [3:0] {
    S_IDLE, S_TRIP, S_DEAD, S_CBW, S_SYN, S_SYNSW, S_RECL, S_POST, S_DYN
  } arc_state_t;
endpackage

// *** arc_grid_model.sv ***
// Purpose: Far side of the reclose sequencer: breaker and synchro-check behaviour
// Assumes: Driven from the bench clock; mode inputs are set by the bench
// Notes:   The breaker recharges after each close, so readiness drops briefly
`timescale 1ns/1ns
module arc_grid_model (
  input  wire logic       clk,
  input  wire logic       close_pulse_out,
  input  wire logic       close_request_out,
  input  wire logic       cb_never,
  input  wire logic [1:0] syn_mode,
  output logic            breaker_ready_in,
  output logic            sync_release_in
);
  logic [2:0] chg_ff = 3'h0;
  logic [2:0] sw_ff  = 3'h0;

  // Spring recharge keeps the breaker not ready while and just after it closes
  always_ff @(posedge clk) begin
    if (close_pulse_out) begin
      chg_ff <= 3'h7;
    end else if (chg_ff != 3'h0) begin
      chg_ff <= chg_ff - 3'h1;
    end
  end
  assign breaker_ready_in = !cb_never && (chg_ff == 3'h0);

  // Mode 2 answers only once switching was requested, and then slowly
  always_ff @(posedge clk) begin
    sw_ff <= close_request_out ? sw_ff + {2'h0, sw_ff != 3'h7} : 3'h0;
  end
  assign sync_release_in = (syn_mode == 2'd0) || (syn_mode == 2'd2 && sw_ff == 3'h7);
endmodule

// *** arc_reclose_tb_top.sv ***
// Purpose: Self-checking bench of the reclose sequencer
// Assumes: Ticks of 4 clocks; settings written in ticks over APB
// Notes:   Timing windows allow for the input filter and the tick phase
`timescale 1ns/1ns
module arc_reclose_tb_top;
  import arc_pkg::*;
  localparam int TK = 4;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        general_trip_in = 1'b0;
  logic        three_phase_trip_in = 1'b0;
  logic        first_cycle_3ph_fault_in = 1'b0;
  logic        reduced_dead_time_in = 1'b0;
  logic        breaker_ready_in;
  logic        sync_release_in;
  logic        protection_start_in = 1'b0;
  logic        manual_close_in = 1'b0;
  logic        close_pulse_out;
  logic        close_request_out;
  logic        blocked_status_out;
  logic        cb_never = 1'b0;
  logic [1:0]  syn_mode = 2'd0;
  logic [31:0] rdat;
  logic        rerr;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          req_n = 0;
  int          step = 0;
  int          cp = 2;
  int          st [16] = '{2, 2, 2, 2, 7, 7, 7, 7, 12, 2, 8, 3, 3, 3, 6, 5};

  arc_reclose #(.TICK_CYCLES(TK)) i_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .general_trip_in(general_trip_in),
    .three_phase_trip_in(three_phase_trip_in),
    .first_cycle_3ph_fault_in(first_cycle_3ph_fault_in),
    .reduced_dead_time_in(reduced_dead_time_in), .breaker_ready_in(breaker_ready_in),
    .sync_release_in(sync_release_in), .protection_start_in(protection_start_in),
    .manual_close_in(manual_close_in), .close_pulse_out(close_pulse_out),
    .close_request_out(close_request_out), .blocked_status_out(blocked_status_out));

  arc_grid_model i_grid (.clk(clk), .close_pulse_out(close_pulse_out),
    .close_request_out(close_request_out), .cb_never(cb_never), .syn_mode(syn_mode),
    .breaker_ready_in(breaker_ready_in), .sync_release_in(sync_release_in));

  always #25 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (close_request_out === 1'b1) begin
      req_n <= req_n + 1;
    end
    if (cyc == 30000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  function automatic logic [7:0] ad(input logic [3:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) chk(n, 0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rdat & m, e);
  endtask

  // Trip pulse; then either a close in the dead-time window or a blocked sequence
  task automatic trip(input logic th, input logic fc, input int dt, input logic cl,
                      input int bw, input logic mc);
    int lat;
    int len;
    lat = 0;
    len = 0;
    general_trip_in <= 1'b1;
    three_phase_trip_in <= th;
    first_cycle_3ph_fault_in <= fc;
    repeat (8) @(posedge clk);
    general_trip_in <= 1'b0;
    three_phase_trip_in <= 1'b0;
    if (mc) begin
      repeat (6) @(posedge clk);
      manual_close_in <= 1'b1;
      repeat (4) @(posedge clk);
      manual_close_in <= 1'b0;
    end
    if (bw > 0) begin
      repeat (bw) @(posedge clk);
      rd(OFS_STAT, 32'h88, 32'h8f);
      chk(32'(blocked_status_out), 32'h1);
    end
    while (close_pulse_out !== 1'b1 && lat < 300) begin
      @(posedge clk);
      lat++;
    end
    while (close_pulse_out === 1'b1 && len < 300) begin
      @(posedge clk);
      len++;
    end
    if (fc) first_cycle_3ph_fault_in <= 1'b0;
    if (cl) chk({30'h0, lat >= dt * TK && lat <= dt * TK + 16,
                 len >= cp * TK - 4 && len <= cp * TK + 4}, 32'h3);
    else chk(lat, 300);
  endtask

  task automatic succ();
    repeat (40) @(posedge clk);
    rd(OFS_STAT, 32'h10000, 32'h1000f);
    apb(1'b1, OFS_STAT, 32'h10000);
    $display("test step %0d finished at %0t ns", ++step, $time);
  endtask

  task automatic idle_ok();
    repeat (60) @(posedge clk);
    chk(32'(blocked_status_out), 32'h0);
    rd(OFS_STAT, 32'h0, 32'hf);
    $display("test step %0d finished at %0t ns", ++step, $time);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h9244));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(ad(RECLAIM_TIME), 32'h3e8, 32'hffffffff);
    rd(OFS_CTRL, 32'h1, 32'hf);
    rd(8'h48, 32'h0, 32'hffffffff);
    chk(32'(rerr), 32'h1);
    for (int i = 0; i < 16; i++) apb(1'b1, ad(4'(i)), st[i]);
    apb(1'b1, OFS_CTRL, 32'h5);
    rd(ad(4'h7), 32'h7, 32'hffff);
    repeat (2) begin
      cp = $urandom_range(4, 1);
      apb(1'b1, ad(CLOSE_PULSE_TIME), cp);
      trip(0, 0, 2, 1, 0, 0);
      succ();
    end
    trip(1, 0, 7, 1, 0, 0);
    succ();
    trip(1, 1, 12, 1, 0, 0);
    succ();
    trip(1, 0, 7, 1, 0, 0);
    trip(0, 0, 7, 1, 0, 0);
    succ();
    trip(0, 0, 2, 1, 0, 0);
    rd(OFS_STAT, 32'h6, 32'h3f);
    succ();
    protection_start_in <= 1'b1;
    trip(0, 0, 2, 1, 0, 0);
    repeat (60) @(posedge clk);
    rd(OFS_STAT, 32'h7, 32'h1000f);
    protection_start_in <= 1'b0;
    trip(0, 0, 2, 1, 0, 0);
    rd(OFS_STAT, 32'h16, 32'h3f);
    succ();
    cp = 12;
    apb(1'b1, ad(CLOSE_PULSE_TIME), cp);
    fork
      trip(0, 0, 2, 1, 0, 0);
      begin
        wait (close_pulse_out === 1'b1);
        repeat (40) @(posedge clk);
        rd(OFS_STAT, 32'h6, 32'h1000f);
      end
    join
    succ();
    cp = 2;
    apb(1'b1, ad(CLOSE_PULSE_TIME), cp);
    apb(1'b1, ad(IDX_DEAD_1PH), 32'h200);
    reduced_dead_time_in <= 1'b1;
    trip(0, 0, 0, 1, 0, 0);
    reduced_dead_time_in <= 1'b0;
    apb(1'b1, ad(IDX_DEAD_1PH), 32'h2);
    succ();
    apb(1'b1, OFS_CTRL, 32'h7);
    trip(1, 0, 0, 0, 4, 0);
    apb(1'b1, OFS_CTRL, 32'h5);
    idle_ok();
    cb_never <= 1'b1;
    trip(0, 0, 0, 0, 30, 0);
    cb_never <= 1'b0;
    idle_ok();
    syn_mode <= 2'd2;
    req_n = 0;
    trip(0, 0, 7, 1, 0, 0);
    chk(32'(req_n > 0), 32'h1);
    succ();
    syn_mode <= 2'd1;
    req_n = 0;
    trip(0, 0, 0, 0, 42, 0);
    chk(32'(req_n >= 8 && req_n <= 13), 32'h1);
    syn_mode <= 2'd0;
    idle_ok();
    trip(1, 0, 0, 0, 4, 1);
    idle_ok();
    manual_close_in <= 1'b1;
    repeat (8) @(posedge clk);
    manual_close_in <= 1'b0;
    chk(32'(blocked_status_out), 32'h1);
    trip(0, 0, 0, 0, 0, 0);
    idle_ok();
    wrap_up();
  end
endmodule
